// ==== verilog/adc_ctrl_regs.svh ====
// constants of the serial conversion controller
// assumes a 125 MHz core clock; included by the SAR engine and the controller
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
`define ADC_CORE_PERIOD_NS 8
`define ADC_OSC_PERIOD_NS 500
`define ADC_OSC_DIV (`ADC_OSC_PERIOD_NS / `ADC_CORE_PERIOD_NS)
`define ADC_FRAME_BITS 5'h10
`define ADC_IDX_SAT 5'h11
`define ADC_EXT_ACQ_FALLS 5'h2
`define ADC_CHANNEL_ID_BIT_POS 5'h4
`define ADC_LEAD_LAST 5'h3
`define ADC_SAR_STEPS 12
`define ADC_LEAD_ONES 3'h7
`define ADC_CHAN_RESET 1'h0
`define ADC_CS_IDLE 1'h1
`endif

// ==== verilog/adc_ctrl_pkg.sv ====
// types of the serial conversion controller
// assumes nothing beyond a SystemVerilog compiler
package adc_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_SHUT = 4'b0001,
    ST_ACQ  = 4'b0010,
    ST_CONV = 4'b0100,
    ST_READ = 4'b1000
  } conv_state_t;
  typedef struct packed {
    logic [9:0] data;
    logic       subHigh;
    logic       subLow;
  } sar_result_t;
  typedef struct packed {
    logic [2:0]  lead;
    logic        channel_id_bit;
    sar_result_t res;
  } frame_t;
endpackage

// ==== verilog/sar_engine.sv ====
// successive approximation register, one decision per step pulse
// assumes compHigh is already synchronous and reflects the current trial code
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module sar_engine #(
  parameter int STEPS = `ADC_SAR_STEPS
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             start,
  input  wire logic             step,
  input  wire logic             compHigh,
  output logic [STEPS-1:0]      trial,
  output logic                  done
);
  localparam logic [STEPS-1:0] TOP = {1'b1, {(STEPS-1){1'b0}}};
  logic [STEPS-1:0] ptr_reg;
  wire  [STEPS-1:0] kept    = compHigh ? trial : (trial & ~ptr_reg);
  wire  [STEPS-1:0] nextPtr = ptr_reg >> 1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial   <= '0;
      ptr_reg <= '0;
      done    <= 1'b0;
    end else if (start) begin
      trial   <= TOP;
      ptr_reg <= TOP;
      done    <= 1'b0;
    end else if (step && !done) begin
      trial   <= kept | nextPtr;
      ptr_reg <= nextPtr;
      done    <= ptr_reg[0];
    end
  end
endmodule // sar_engine

// ==== verilog/adc_serial_conversion_ctrl.sv ====
// conversion sequencing and serial readout of a two-channel 10-bit converter
// assumes select_n_shutdown, serialClk and compHigh are asynchronous pins
// Operation
// RQ1: after power-on reset the first conversion uses input channel A.
// RQ2: each chip-select toggle advances channel pointer, alternating A and B.
// RQ3: host toggles chip select twice to convert the same channel again.
// RQ4: every frame carries the channel id bit just before the data MSB.
// RQ5: serial data output changes only on serial clock falling edges.
// RQ6: serial data output is high impedance while chip select is high.
// RQ7: chip select high puts the whole device into shutdown.
// RQ8: track/hold starts tracking at the chip-select falling edge.
// RQ9: external mode acquisition ends at second serial clock falling edge.
// RQ10: internal mode acquisition ends at first serial clock falling edge.
// RQ11: at acquisition end track/hold opens and holds the sample.
// RQ12: host keeps serial clock within the mode's frequency limits.
// RQ13: a nominal conversion and readout cycle takes 16 serial clocks.
// RQ14: serial clock level at chip-select fall picks internal or external mode.
// RQ15: frame is three ones, channel bit, ten data bits, two sub bits.
// RQ16: after the last sub bit further clocks shift out zeros.
// RQ17: internal conversion end stops oscillator and drives data output high.
// RQ18: host samples each output bit on the serial clock rising edge.
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module adc_serial_conversion_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int OSC_DIV = `ADC_OSC_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        select_n_shutdown,
  input  wire logic        serialClk,
  input  wire logic        compHigh,
  output logic             serialDataOut,
  output logic             serialDataOe,
  output logic             trackHold,
  output logic             channelB,
  output logic             powerUp,
  output logic             oscRun,
  output logic [11:0]      dacCode
);
  logic [1:0]  rstPipe;
  logic [2:0]  csPipe;
  logic [2:0]  sclkPipe;
  logic [1:0]  compPipe;
  conv_state_t state_reg;
  conv_state_t state_next;
  logic        modeInt_reg;
  logic        channelB_reg;
  logic        track_reg;
  logic        powerUp_reg;
  logic        oscRun_reg;
  logic [4:0]  bitIdx_reg;
  logic        dout_reg;
  logic        doutOe_reg;
  logic [7:0]  oscCnt_reg;
  logic        anyConv_reg;
  logic        sarDone;
  logic [11:0] sarTrial;

  // reset released through two flops, asserted at once
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstPipe <= 2'b00;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  wire rstN = rstPipe[1];

  // pins pass two flops; the third stage only serves edge finding
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      csPipe   <= {3{`ADC_CS_IDLE}};
      sclkPipe <= 3'b000;
      compPipe <= 2'b00;
    end else begin
      csPipe   <= {csPipe[1:0], select_n_shutdown};
      sclkPipe <= {sclkPipe[1:0], serialClk};
      compPipe <= {compPipe[0], compHigh};
    end
  end

  wire csLow     = ~csPipe[1];
  wire csFall    = csPipe[2] & ~csPipe[1];
  wire csRise    = ~csPipe[2] & csPipe[1];
  wire sclkFall  = sclkPipe[2] & ~sclkPipe[1];
  wire sclkRise  = ~sclkPipe[2] & sclkPipe[1];
  wire sclkLevel = sclkPipe[1];

  function automatic logic frame_bit(frame_t f, logic [4:0] idx);
    logic [4:0] pos;
    pos = `ADC_FRAME_BITS - idx;
    if (idx == 5'd0 || idx > `ADC_FRAME_BITS) begin
      return 1'b0;
    end
    return f[pos[3:0]];
  endfunction

  wire inShut = state_reg == ST_SHUT;
  wire inAcq  = state_reg == ST_ACQ;
  wire inConv = state_reg == ST_CONV;
  wire inRead = state_reg == ST_READ;

  // index of the frame bit shown after this fall; sticks past the end
  wire [4:0] idxInc = (bitIdx_reg == `ADC_IDX_SAT) ? bitIdx_reg : bitIdx_reg + 5'd1;

  wire sar_result_t sarRes = sar_result_t'(sarTrial);
  wire frame_t frameWord = '{lead: `ADC_LEAD_ONES, channel_id_bit: channelB_reg, res: sarRes}; // [RQ4] [RQ15]
  wire frameBit = frame_bit(frameWord, idxInc); // [RQ15] [RQ16]

  // acquisition ends at the mode's own fall; in external mode that fall also shifts
  wire acqEnd = inAcq & sclkFall & (modeInt_reg | idxInc == `ADC_EXT_ACQ_FALLS); // [RQ9] [RQ10]
  wire eoc    = inConv & sarDone;
  // external mode: every fall in acquisition and readout shifts a frame bit
  wire shiftFall = sclkFall & (inRead | (inAcq & ~modeInt_reg)); // [RQ5] [RQ13]

  wire oscTick = oscRun_reg & (oscCnt_reg == 8'(OSC_DIV - 1));
  // external mode decisions ride on rises so each bit is settled before its fall
  wire sarStep = (inConv & oscTick) | (inRead & ~modeInt_reg & sclkRise);

  always_comb begin
    state_next = state_reg;
    if (!csLow) begin
      state_next = ST_SHUT; // [RQ7]
    end else begin
      unique case (state_reg)
        ST_SHUT: begin
          if (csFall) begin
            state_next = ST_ACQ;
          end
        end
        ST_ACQ: begin
          if (acqEnd) begin
            state_next = modeInt_reg ? ST_CONV : ST_READ;
          end
        end
        ST_CONV: begin
          if (sarDone) begin
            state_next = ST_READ;
          end
        end
        ST_READ: begin
          state_next = ST_READ;
        end
      endcase
    end
  end
  wire activeNext = state_next != ST_SHUT;

  wire [4:0] idxNext = csFall    ? 5'd0 :
                       eoc       ? 5'd1 :
                       shiftFall ? idxInc : bitIdx_reg;
  // output moves only at a fall, plus the end-of-conversion flag
  wire doutNext = csFall    ? 1'b0 :
                  eoc       ? 1'b1 :
                  shiftFall ? frameBit : dout_reg; // [RQ5] [RQ17]
  // tracking only between the select fall and the end of acquisition
  wire trackNext = csFall            ? 1'b1 :
                   (acqEnd | ~csLow) ? 1'b0 : track_reg; // [RQ8] [RQ11]
  // deselect wins, so a clock fall racing the select rise cannot wake the oscillator
  wire oscNext = ~csLow                 ? 1'b0 :
                 (acqEnd & modeInt_reg) ? 1'b1 :
                 eoc                    ? 1'b0 : oscRun_reg; // [RQ7] [RQ17]

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= ST_SHUT;
      modeInt_reg <= 1'b0;
      channelB_reg <= `ADC_CHAN_RESET; // [RQ1]
      anyConv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (csFall) begin
        modeInt_reg <= sclkLevel; // [RQ14]
      end
      if (csRise) begin
        // the pointer moves on every toggle, so skipping needs two
        channelB_reg <= ~channelB_reg; // [RQ2] [RQ3]
        anyConv_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bitIdx_reg <= 5'd0;
      dout_reg <= 1'b0;
      track_reg <= 1'b0;
      oscRun_reg <= 1'b0;
    end else begin
      bitIdx_reg <= idxNext;
      dout_reg <= activeNext & doutNext;
      track_reg <= trackNext;
      oscRun_reg <= oscNext;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      doutOe_reg <= 1'b0;
      powerUp_reg <= 1'b0;
      oscCnt_reg <= 8'h00;
    end else begin
      doutOe_reg <= activeNext; // [RQ6]
      powerUp_reg <= activeNext; // [RQ7]
      oscCnt_reg <= (oscTick | ~oscRun_reg) ? 8'h00 : oscCnt_reg + 8'h01;
    end
  end

  // conversion steps come from the divided oscillator or from serial clock rises
  sar_engine #(
    .STEPS(`ADC_SAR_STEPS)
  ) u_sar (
    .clk      (core_clk),
    .rst_n    (rstN),
    .start    (acqEnd), // [RQ11]
    .step     (sarStep),
    .compHigh (compPipe[1]),
    .trial    (sarTrial),
    .done     (sarDone)
  );

  assign serialDataOut = dout_reg;
  assign serialDataOe  = doutOe_reg;
  assign trackHold     = track_reg;
  assign channelB      = channelB_reg;
  assign powerUp       = powerUp_reg;
  assign oscRun        = oscRun_reg;
  assign dacCode       = sarTrial;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN);

  // checks watch the synchronised pins, which trail the pads by two cycles
  a_first_chan_a: assert property (csFall && !anyConv_reg |-> !channelB_reg) // [RQ1]
    else $error("first conversion not on channel A");

  a_chan_alternate: assert property (csRise |=> channelB_reg != $past(channelB_reg)) // [RQ2]
    else $error("channel pointer did not advance");

  a_channel_id_bit_placed: assert property (shiftFall && idxInc == `ADC_CHANNEL_ID_BIT_POS |=> dout_reg == channelB_reg) // [RQ4]
    else $error("channel bit missing before MSB");

  a_dout_on_fall: assert property ($changed(dout_reg) |-> $past(sclkFall) || $past(eoc) || $past(!csLow)) // [RQ5]
    else $error("data output moved off a falling edge");

  a_hiz_shutdown: assert property (csPipe[1] |=> !doutOe_reg) // [RQ6]
    else $error("output driven while deselected");

  a_wake_on_fall: assert property (csFall |=> doutOe_reg && powerUp_reg && !dout_reg) // [RQ6] [RQ7]
    else $error("device not awake after select");

  a_shutdown_all: assert property (csPipe[1] |=> inShut && !powerUp_reg && !oscRun_reg && !track_reg) // [RQ7]
    else $error("device not shut down");

  a_track_on_fall: assert property (csFall |=> track_reg && inAcq) // [RQ8]
    else $error("tracking did not start");

  a_ext_acq_end: assert property (inAcq && !modeInt_reg && sclkFall && bitIdx_reg == 5'd1 // [RQ9]
    |=> !track_reg && inRead)
    else $error("external acquisition not ended at second fall");

  a_ext_no_osc: assert property (!modeInt_reg && !inShut |-> !oscRun_reg) // [RQ9]
    else $error("oscillator running in external mode");

  a_int_acq_end: assert property (inAcq && modeInt_reg && sclkFall && csLow // [RQ10]
    |=> !track_reg && inConv && oscRun_reg)
    else $error("internal acquisition not ended at first fall");

  a_hold_kept: assert property (inRead && csLow |=> !track_reg) // [RQ11]
    else $error("track/hold reopened during conversion");

  a_hold_in_conv: assert property (inConv |-> !track_reg) // [RQ11]
    else $error("track/hold open while converting");

  a_sar_start: assert property (acqEnd && csLow |=> sarTrial == 12'h800) // [RQ11]
    else $error("conversion did not start from the top code");

  a_mode_latch: assert property (csFall |=> modeInt_reg == $past(sclkLevel)) // [RQ14]
    else $error("clock mode not latched");

  a_lead_ones: assert property (shiftFall && idxInc <= `ADC_LEAD_LAST |=> dout_reg) // [RQ15]
    else $error("leading one missing");

  a_trailing_zero: assert property (shiftFall && bitIdx_reg >= `ADC_FRAME_BITS |=> !dout_reg) // [RQ13] [RQ16]
    else $error("trailing bit not zero");

  a_eoc_high: assert property (eoc && csLow |=> dout_reg && !oscRun_reg && inRead) // [RQ17]
    else $error("end of conversion not flagged");

  a_conv_quiet: assert property (inConv && !sarDone && csLow |=> bitIdx_reg == 5'd0 && !dout_reg) // [RQ17]
    else $error("output moved during internal conversion");

  // main scenarios: both modes, channel B, trailing zeros, a bare skip toggle
  c_ext_frame: cover property (inRead && !modeInt_reg && bitIdx_reg == `ADC_FRAME_BITS);
  c_int_eoc: cover property (eoc && csLow);
  c_chan_b: cover property (inRead && channelB_reg && bitIdx_reg == `ADC_CHANNEL_ID_BIT_POS);
  c_trailing: cover property (inRead && bitIdx_reg == `ADC_IDX_SAT && sclkFall);
  c_skip_toggle: cover property (csRise && inAcq);
endmodule // adc_serial_conversion_ctrl

// ==== testbench/host_master.sv ====
// serial host model: chip select and serial clock out, data captured on clock rises
// assumes the controller answers each clock fall well within half a clock period
`timescale 1ns/1ns
module host_master (
  input  wire logic serialDataOut,
  input  wire logic serialDataOe,
  input  wire logic trackHold,
  input  wire logic oscRun,
  output logic      csN,
  output logic      sclk
);
  // period scaled down for run time; the core only counts edges, no rate limit of its own
  localparam int HALF = 32;
  logic lastPin;
  logic pin;
  // released pin shows the inverse of the last driven value, never a stale copy
  assign pin = serialDataOe ? serialDataOut : ~lastPin;
  always @(serialDataOut) if (serialDataOe) lastPin = serialDataOut;
  initial begin
    csN = 1'b1;
    sclk = 1'b0;
    lastPin = 1'b0;
  end
  task automatic frame(input bit intMode, input int nCap, output logic [17:0] bits, output logic [5:0] st);
    int w;
    bits = '0;
    st = 6'h01;
    sclk = intMode;  // clock level before select picks the mode
    #(2*HALF) csN = 1'b0;
    #(2*HALF) st[5] = trackHold;
    if (intMode) begin
      sclk = 1'b0;
      #HALF st[4] = trackHold;
      st[3] = oscRun;
      w = 0;
      while (pin !== 1'b1 && w < 400) begin
        #8 w++;
      end
      #HALF;
    end else begin
      sclk = 1'b1;
      #HALF sclk = 1'b0;
      #HALF st[4] = trackHold;
      st[3] = oscRun;
    end
    for (int i = 0; i < nCap; i++) begin
      bits[17-i] = pin;  // taken on the rise, midway between falls
      if (i == 0) st[2] = oscRun;
      if (i == 1) st[1] = trackHold;
      sclk = 1'b1;
      #(HALF-2) if (pin !== bits[17-i]) st[0] = 1'b0;
      #2 sclk = 1'b0;
      #HALF;
    end
    csN = 1'b1;
    #(2*HALF);
  endtask
  // a bare select pulse only steps the channel, used to convert one input twice
  task automatic toggle();
    #(2*HALF) csN = 1'b0;
    #(2*HALF) csN = 1'b1;
    #(2*HALF);
  endtask
endmodule // host_master

// ==== testbench/testbench.sv ====
// self-checking bench: host model frames compared with a channel and data model
// assumes a comparator on dacCode; analog inputs are random 12-bit codes
`timescale 1ns/1ns
module testbench;
  import adc_ctrl_pkg::*;
  localparam int OSC = 4;
  logic        core_clk;
  logic        arst_n;
  logic        compHigh;
  logic        serialDataOut;
  logic        serialDataOe;
  logic        trackHold;
  logic        channelB;
  logic        powerUp;
  logic        oscRun;
  logic        csN;
  logic        sclk;
  logic [11:0] dacCode;
  logic [11:0] anaA;
  logic [11:0] anaB;
  logic [31:0] seed;
  logic [17:0] bits;
  logic [5:0]  st;
  frame_t      expFrame;
  logic [17:0] expQ[$];
  int          fail_count;
  int          n_compared;
  int          expCh;
  adc_serial_conversion_ctrl #(.OSC_DIV(OSC)) dut (.core_clk(core_clk), .arst_n(arst_n),
    .select_n_shutdown(csN), .serialClk(sclk), .compHigh(compHigh), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe), .trackHold(trackHold), .channelB(channelB), .powerUp(powerUp),
    .oscRun(oscRun), .dacCode(dacCode));
  host_master host (.serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .trackHold(trackHold),
    .oscRun(oscRun), .csN(csN), .sclk(sclk));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // ideal comparator on the muxed input
  always @(negedge core_clk) compHigh <= (((channelB === 1'b1) ? anaB : anaA) >= dacCode);
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmpBit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic cmpFrame(input string what, input logic [17:0] e, input logic [17:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic checkIdle();
    cmpBit("output enable idle", 1'b0, serialDataOe);
    cmpBit("awake idle", 1'b0, powerUp);
    cmpBit("oscillator idle", 1'b0, oscRun);
    cmpBit("channel pointer", expCh[0], channelB);
  endtask
  task automatic runFrame(input bit intMode, input int nCap);
    logic [17:0] keep;
    seed = nextRand(seed);
    anaA = seed[11:0];
    anaB = seed[23:12];
    expFrame = {3'h7, expCh[0], (expCh[0] ? anaB : anaA)};
    expQ.push_back({expFrame, 2'h0});
    // a cut frame is compared over the bits actually clocked out
    keep = ~(18'h3ffff >> nCap);
    host.frame(intMode, nCap, bits, st);
    cmpFrame("frame", expQ.pop_front() & keep, bits);
    cmpBit("track at select", 1'b1, st[5]);
    cmpBit("track after first fall", !intMode, st[4]);
    cmpBit("oscillator converting", intMode, st[3]);
    cmpBit("oscillator after result", 1'b0, st[2]);
    cmpBit("track holding", 1'b0, st[1]);
    cmpBit("data steady while clock high", 1'b1, st[0]);
    expCh ^= 1;
    checkIdle();
  endtask
  initial begin
    arst_n = 1'b0;
    compHigh = 1'b0;
    anaA = '0;
    anaB = '0;
    seed = 32'h9bd2f433;
    fail_count = 0;
    n_compared = 0;
    expCh = 0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    cmpBit("channel after reset", 1'b0, channelB);
    cmpBit("enable after reset", 1'b0, serialDataOe);
    runFrame(1'b0, 18);
    runFrame(1'b1, 18);
    // release in mid-frame still steps the pointer
    runFrame(1'b0, 6);
    host.toggle();
    expCh ^= 1;
    checkIdle();
    runFrame(1'b1, 18);
    for (int i = 0; i < 12; i++) begin
      seed = nextRand(seed);
      runFrame(seed[31], 18);
    end
    // second reset with the pointer on channel B: it must return to channel A
    @(negedge core_clk) arst_n = 1'b0;
    repeat (4) @(negedge core_clk);
    cmpBit("enable in reset", 1'b0, serialDataOe);
    arst_n = 1'b1;
    repeat (8) @(negedge core_clk);
    expCh = 0;
    cmpBit("channel after second reset", 1'b0, channelB);
    runFrame(1'b1, 18);
    give_verdict();
  end
  // whole run needs some 25 to 30 us; the 200 us limit leaves wide margin
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule // testbench
